//--- rtl/pllc_ctrl.sv
`default_nettype none
// ---------------------------------------------------------------
// Lock detection, pump control, fast lock, calibration and outputs
// ---------------------------------------------------------------
// Behaviour
// R01: Lock decided from up and down pulses
// R02: Polarity bit inverts lock output
// R03: Cycle in lock when skew below threshold
// R04: Lock after run of good cycles
// R05: Five-bit code sets pump current
// R06: Fast lock raises current, cuts damping
// R07: Fast-lock state lasts 13-bit cycle count
// R08: Slip boost until locking ends
// R09: Auto select oscillator and sub-band
// R10: Master write starts calibration unless disabled
// R11: Tune voltage forced during calibration
// R12: Host supplies stable reference before calibration
// R13: Calibration takes about 13 cal cycles
// R14: Cal clock is compare rate divided
// R15: Integer mode uses divider of one
// R16: High compare rate needs two-step calibration
// R17: Hopping may use faster cal clock
// R18: Lock loss relaunches calibration if enabled
// R19: Software or pin powers down buffer
// R20: Mute keeps outputs off until lock
// R21: Host never enables both buffers
// R22: Calibration disable bit reads as one
// R23: Failed cycle clears run and lock
// R24: New frequency loads fast-lock timer; code loads it only when divider bits 12:0 are nonzero
module pllc_ctrl (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog loop pins
    input  wire logic        compareClk,          // Divided reference, one edge per cycle
    input  wire logic        pfdUp,               // Detector up pulse
    input  wire logic        pfdDown,             // Detector down pulse
    input  wire logic        oscFast,             // Oscillator above target during search
    // Hardware power-down pins
    input  wire logic        primary_output_powerdown_pin,
    input  wire logic        secondary_output_powerdown_pin,
    // Loop controls
    output logic             lockOut,             // Lock indicator pin
    output logic      [4:0]  pump_current_code,
    output logic             dampReduce,          // Reduced loop filter resistance
    output logic             oscillator_tune_voltage_force,
    output logic      [7:0]  oscSelectWord,       // Oscillator and sub-band select
    output logic      [16:0] divideValue,         // Integer divider to the loop
    // Output buffers
    output logic             primaryOutEnable,
    output logic             secondaryOutEnable
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [5:0] pinSync;                          // Synchronised pins
    logic       compareLast;                      // Previous compare clock level

    pllc_sync #(.WIDTH(6)) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .asyncIn ({oscFast, compareClk, pfdUp, pfdDown,
                   primary_output_powerdown_pin, secondary_output_powerdown_pin}),
        .syncOut (pinSync)
    );

    wire compareLvl = pinSync[4];
    wire upLvl      = pinSync[3];
    wire downLvl    = pinSync[2];
    wire pinPd1     = pinSync[1];
    wire pinPd2     = pinSync[0];
    wire compareTick = compareLvl && !compareLast; // Rising edge of compare clock

    // Edge detector on the synchronised level
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) compareLast <= 1'b0;
        else          compareLast <= compareLvl;
    end

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [31:0] masterReg;                       // Divider, pump code, cal disable
    logic [31:0] lockCfgReg;                      // Lock detector setup
    logic [31:0] fastCfgReg;                      // Fast-lock setup
    logic [9:0]  calDivReg;                       // Calibration clock divider
    logic [31:0] outCfgReg;                       // Output control
    logic [31:0] readData;                        // Read multiplexer

    wire wrAccess  = psel && penable && pwrite;
    wire rdSetup   = psel && !penable && !pwrite;
    wire hitMaster = (paddr == pllc_pkg::MASTER_OFS);
    wire hitLock   = (paddr == pllc_pkg::LOCK_CFG_OFS);
    wire hitFast   = (paddr == pllc_pkg::FAST_CFG_OFS);
    wire hitDiv    = (paddr == pllc_pkg::CAL_DIV_OFS);
    wire hitOut    = (paddr == pllc_pkg::OUT_CFG_OFS);
    wire hitStatus = (paddr == pllc_pkg::STATUS_OFS);
    wire hitAny    = hitMaster || hitLock || hitFast || hitDiv || hitOut || hitStatus;
    wire masterWr  = wrAccess && hitMaster;       // Marks a new frequency

    // Zero wait states; unmapped accesses or read-only writes flag an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!hitAny || (pwrite && hitStatus));

    // Configuration writes at the access edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            masterReg  <= pllc_pkg::MASTER_RST;
            lockCfgReg <= pllc_pkg::LOCK_CFG_RST;
            fastCfgReg <= pllc_pkg::FAST_CFG_RST;
            calDivReg  <= pllc_pkg::CAL_DIV_RST;
            outCfgReg  <= pllc_pkg::OUT_CFG_RST;
        end else if (wrAccess) begin
            if (hitMaster) masterReg  <= pwdata;
            if (hitLock)   lockCfgReg <= pwdata;
            if (hitFast)   fastCfgReg <= pwdata;
            if (hitDiv)    calDivReg  <= pwdata[9:0];
            if (hitOut)    outCfgReg  <= pwdata;
        end
    end

    // ---------------------------------------------------------------
    // Decoded configuration
    // ---------------------------------------------------------------
    wire [4:0]  progCode    = masterReg[pllc_pkg::PUMP_LSB +: pllc_pkg::PUMP_W];
    wire        calDisable  = masterReg[pllc_pkg::CALDIS_BIT];
    wire [2:0]  thrCode     = lockCfgReg[pllc_pkg::THR_LSB +: 3];
    wire [2:0]  runCode     = lockCfgReg[pllc_pkg::CNT_LSB +: 3];
    wire        polInvert   = lockCfgReg[pllc_pkg::POL_BIT];
    wire        autoRestart = lockCfgReg[pllc_pkg::AUTO_BIT];
    wire [12:0] fastCount   = fastCfgReg[pllc_pkg::FAST_W-1:0];
    wire        fastEnable  = fastCfgReg[pllc_pkg::FASTEN_BIT];
    wire        slipEnable  = fastCfgReg[pllc_pkg::SLIPEN_BIT];
    wire        swPd1       = outCfgReg[pllc_pkg::PD1_BIT];
    wire        swPd2       = outCfgReg[pllc_pkg::PD2_BIT];
    wire        muteEnable  = outCfgReg[pllc_pkg::MUTE_BIT];
    wire [3:0]  thrCycles   = pllc_pkg::thr_cycles(thrCode);
    wire [12:0] runTarget   = pllc_pkg::RUN_LEN[runCode];

    assign divideValue = masterReg[pllc_pkg::NDIV_LSB +: pllc_pkg::NDIV_W];

    // ---------------------------------------------------------------
    // Lock detector
    // ---------------------------------------------------------------
    logic [3:0]  skewCnt;                         // Cycles with one pulse only
    logic [12:0] runCnt;                          // Consecutive good compare cycles
    logic        lockInt;                         // Internal lock state
    logic        lockLast;                        // For loss-of-lock edge
    logic [1:0]  failRun;                         // Consecutive failed cycles, saturating

    // Skew is the time up and down disagree; resolution is one mclk period
    wire skewing  = upLvl ^ downLvl;              // see R01
    wire cycleOk  = (skewCnt < thrCycles);        // see R03

    // Accumulate skew over one compare cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)         skewCnt <= '0;
        else if (compareTick) skewCnt <= {3'h0, skewing};
        else if (skewing && skewCnt != 4'hF) skewCnt <= skewCnt + 4'h1;
    end

    // Run counter; any bad cycle starts the run again
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            runCnt  <= '0;
            lockInt <= 1'b0;
            failRun <= '0;
        end else if (compareTick) begin
            if (!cycleOk) begin
                runCnt  <= '0;                    // see R23
                lockInt <= 1'b0;                  // see R23
                if (failRun != 2'h3) failRun <= failRun + 2'h1;
            end else begin
                failRun <= '0;
                if (runCnt < runTarget) runCnt <= runCnt + 13'h0001;
                if (runCnt + 13'h0001 >= runTarget) lockInt <= 1'b1;  // see R04
            end
        end
    end

    // Previous lock level for edge detection
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) lockLast <= 1'b0;
        else          lockLast <= lockInt;
    end

    // Registered lock pin with optional inversion
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) lockOut <= 1'b0;
        else          lockOut <= lockInt ^ polInvert;  // see R02
    end

    // ---------------------------------------------------------------
    // Fast lock timer and slip boost
    // ---------------------------------------------------------------
    logic [12:0] fastTimer;                       // Remaining wide-band cycles
    logic        fastActive;                      // Wide-band state
    logic        slipBoost;                       // Large frequency error boost

    // Loaded on a new frequency whose divider bits 12:0 are nonzero, counts compare cycles
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fastTimer  <= '0;
            fastActive <= 1'b0;
        end else if (masterWr && fastEnable && pwdata[12:0] != 13'h0000) begin
            fastTimer  <= fastCount;              // see R24
            fastActive <= (fastCount != 13'h0000);
        end else if (compareTick && fastActive) begin
            fastTimer  <= fastTimer - 13'h0001;   // see R07
            if (fastTimer <= 13'h0001) fastActive <= 1'b0;
        end
    end

    // Two failed cycles in a row count as a large error; lock ends the boost
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)                       slipBoost <= 1'b0;
        else if (!slipEnable || lockInt)    slipBoost <= 1'b0;      // see R08
        else if (compareTick && failRun != 2'h0 && !cycleOk) slipBoost <= 1'b1;
    end

    // Pump code and damping, registered toward the analog side
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pump_current_code <= '0;
            dampReduce        <= 1'b0;
        end else begin
            pump_current_code <= (fastActive || slipBoost) ? pllc_pkg::PUMP_MAX  // see R06
                                                           : progCode;          // see R05
            dampReduce        <= fastActive;      // see R06
        end
    end

    // ---------------------------------------------------------------
    // Calibration
    // ---------------------------------------------------------------
    logic       calBusy;                          // Sequencer running
    logic [7:0] calWord;                          // Search result

    // A master write carries its own disable bit, so decide from the written data
    wire startOnWrite = masterWr && !pwdata[pllc_pkg::CALDIS_BIT];            // see R10
    wire startOnLoss  = autoRestart && !calDisable && lockLast && !lockInt;  // see R18
    wire calStart     = startOnWrite || startOnLoss;

    pllc_calib #(
        .CYCLES (pllc_pkg::CAL_CYCLES),
        .WORD_W (pllc_pkg::CAL_WORD_W)
    ) u_calib (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .compareTick (compareTick),
        .divRatio    (calDivReg),               // see R15
        .start       (calStart),
        .oscFast     (pinSync[5]),
        .busy        (calBusy),
        .calWord     (calWord)
    );

    // Tune hold and select word toward the oscillators
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            oscillator_tune_voltage_force <= 1'b0;
            oscSelectWord                 <= '0;
        end else begin
            oscillator_tune_voltage_force <= calBusy || calStart;  // see R11
            oscSelectWord                 <= calWord;              // see R09
        end
    end

    // ---------------------------------------------------------------
    // Output buffer gating
    // ---------------------------------------------------------------
    wire muteHold = muteEnable && !lockInt;       // see R20
    wire pd1      = swPd1 || pinPd1;              // see R19
    wire pd2      = swPd2 || pinPd2;              // see R19

    // Both enables are independent; exclusivity is left to software
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            primaryOutEnable   <= 1'b0;
            secondaryOutEnable <= 1'b0;
        end else begin
            primaryOutEnable   <= !pd1 && !muteHold;
            secondaryOutEnable <= !pd2 && !muteHold;
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    wire [31:0] statusWord = {18'h00000, oscSelectWord, slipBoost, fastActive,
                              calBusy, primaryOutEnable, secondaryOutEnable, lockInt};

    // Disable bit cannot be read back
    always_comb begin
        readData = 32'h0000_0000;
        if (hitMaster) readData = masterReg | (32'h0000_0001 << pllc_pkg::CALDIS_BIT); // see R22
        if (hitLock)   readData = {24'h000000, lockCfgReg[7:0]};
        if (hitFast)   readData = {17'h00000, fastCfgReg[14:0]};
        if (hitDiv)    readData = {22'h000000, calDivReg};
        if (hitOut)    readData = {29'h00000000, outCfgReg[2:0]};
        if (hitStatus) readData = statusWord;
    end

    // Read data captured in the setup cycle, stable through access
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)    prdata <= '0;
        else if (rdSetup) prdata <= readData;
    end
endmodule
`default_nettype wire

//--- rtl/pllc_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// Shared constants for the lock and calibration controller
// ---------------------------------------------------------------
package pllc_pkg;
    // Register byte offsets
    localparam logic [7:0] MASTER_OFS    = 8'h00;  // Divider, pump code, cal disable
    localparam logic [7:0] LOCK_CFG_OFS  = 8'h04;  // Lock detector setup
    localparam logic [7:0] FAST_CFG_OFS  = 8'h08;  // Fast-lock and slip setup
    localparam logic [7:0] CAL_DIV_OFS   = 8'h0C;  // Calibration clock divider
    localparam logic [7:0] OUT_CFG_OFS   = 8'h10;  // Output buffer control
    localparam logic [7:0] STATUS_OFS    = 8'h14;  // Read-only state
    // Master register fields
    localparam int NDIV_LSB   = 0;                 // Integer divider, 17 bits
    localparam int NDIV_W     = 17;
    localparam int PUMP_LSB   = 17;                // Pump current code, 5 bits
    localparam int PUMP_W     = 5;
    localparam int CALDIS_BIT = 22;                // Calibration disable
    // Lock configuration fields
    localparam int THR_LSB    = 0;                 // Skew threshold code
    localparam int CNT_LSB    = 3;                 // Run length code
    localparam int POL_BIT    = 6;                 // Lock output inversion
    localparam int AUTO_BIT   = 7;                 // Calibration auto restart
    // Fast-lock configuration fields
    localparam int FAST_W     = 13;                // Fast-lock timer width
    localparam int FASTEN_BIT = 13;
    localparam int SLIPEN_BIT = 14;
    // Output control fields
    localparam int PD1_BIT    = 0;
    localparam int PD2_BIT    = 1;
    localparam int MUTE_BIT   = 2;
    // Values after reset
    localparam logic [31:0] MASTER_RST   = 32'h0000_0000;
    localparam logic [31:0] LOCK_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] FAST_CFG_RST = 32'h0000_0000;
    localparam logic [9:0]  CAL_DIV_RST  = 10'h001;
    localparam logic [31:0] OUT_CFG_RST  = 32'h0000_0003;  // Both buffers off
    // Timing
    localparam int CLK_MHZ    = 125;               // mclk rate
    localparam int THR_MIN_NS = 2;                 // Smallest skew threshold
    localparam int THR_MAX_NS = 16;                // Largest skew threshold
    localparam int THR_STEP_NS = (THR_MAX_NS - THR_MIN_NS) / 7;
    localparam int CAL_CYCLES = 13;                // Calibration clock cycles per run
    localparam int CAL_WORD_W = 8;                 // Oscillator select plus sub-band
    // Lock run lengths, 4 up to 4096 compare cycles
    localparam logic [12:0] RUN_LEN [8] = '{13'h0004, 13'h0010, 13'h0040, 13'h0080,
                                            13'h0100, 13'h0200, 13'h0400, 13'h1000};
    localparam logic [PUMP_W-1:0] PUMP_MAX = 5'h1F; // Boost code
    // Skew threshold in mclk cycles, longest time rounded down, at least one
    function automatic logic [3:0] thr_cycles(input logic [2:0] code);
        int ns;
        int cyc;
        ns  = THR_MIN_NS + int'(code) * THR_STEP_NS;
        cyc = (ns * CLK_MHZ) / 1000;
        if (cyc < 1) cyc = 1;
        return 4'(cyc);
    endfunction
endpackage
`default_nettype wire

//--- rtl/pllc_sync.sv
`default_nettype none
// ---------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ---------------------------------------------------------------
module pllc_sync #(
    parameter int WIDTH = 1                        // Number of bits
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1Reg;                   // Read only by the second stage

    // Two flops, first one feeds nothing else
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage1Reg <= '0;
            syncOut   <= '0;
        end else begin
            stage1Reg <= asyncIn;
            syncOut   <= stage1Reg;
        end
    end
endmodule
`default_nettype wire

//--- rtl/pllc_calib.sv
`default_nettype none
// ---------------------------------------------------------------
// Oscillator and sub-band calibration sequencer
// ---------------------------------------------------------------
module pllc_calib #(
    parameter int CYCLES = pllc_pkg::CAL_CYCLES,   // Calibration clock cycles per run
    parameter int WORD_W = pllc_pkg::CAL_WORD_W    // Select word width
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              reset_n,
    // Control
    input  wire logic              compareTick,    // One pulse per compare cycle
    input  wire logic [9:0]        divRatio,       // Calibration clock divider
    input  wire logic              start,          // Launch a run
    input  wire logic              oscFast,        // Oscillator above target
    // Results
    output logic                   busy,
    output logic      [WORD_W-1:0] calWord
);
    typedef enum logic [2:0] {
        CAL_IDLE   = 3'b001,
        CAL_SEARCH = 3'b010,
        CAL_SETTLE = 3'b100
    } pllc_cal_type;

    pllc_cal_type state;                           // Sequencer state
    logic [9:0]   divCnt;                          // Compare cycles since last cal tick
    logic [3:0]   stepCnt;                         // Cal ticks in this run
    logic [WORD_W-1:0] probeBit;                   // Bit under trial
    wire  divZero  = (divRatio == 10'h000);
    wire  calTick  = compareTick && (divZero || divCnt >= divRatio - 10'h001);  // see R14

    // Divide the compare rate into the calibration rate
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) divCnt <= '0;
        else if (start || calTick) divCnt <= '0;
        else if (compareTick) divCnt <= divCnt + 10'h001;
    end

    // Successive approximation on the select word, padded to the run length
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state    <= CAL_IDLE;
            stepCnt  <= '0;
            probeBit <= '0;
            calWord  <= '0;
        end else if (start) begin                  // see R09
            state    <= CAL_SEARCH;
            stepCnt  <= '0;
            probeBit <= {1'b1, {(WORD_W-1){1'b0}}};
            calWord  <= {1'b1, {(WORD_W-1){1'b0}}};
        end else if (calTick) begin
            case (state)
                CAL_IDLE: ;
                CAL_SEARCH: begin
                    stepCnt  <= stepCnt + 4'h1;
                    probeBit <= probeBit >> 1;
                    calWord  <= (oscFast ? (calWord & ~probeBit) : calWord) | (probeBit >> 1);
                    if (probeBit[0]) state <= CAL_SETTLE;
                end
                CAL_SETTLE: begin
                    stepCnt <= stepCnt + 4'h1;
                    if (stepCnt >= 4'(CYCLES - 1)) state <= CAL_IDLE;  // see R13
                end
                default: state <= CAL_IDLE;
            endcase
        end
    end

    assign busy = (state != CAL_IDLE);
endmodule
`default_nettype wire

//--- sim/pllc_sva.sv
`default_nettype none
// Port-level checks on the lock and calibration controller
module pllc_sva (
    input wire logic        mclk, reset_n, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        primary_output_powerdown_pin, secondary_output_powerdown_pin,
    input wire logic        primaryOutEnable, secondaryOutEnable, dampReduce, oscillator_tune_voltage_force,
    input wire logic [4:0]  pump_current_code
);
    wire cal = oscillator_tune_voltage_force;  // Short alias
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Master write with calibration left enabled, then a minimum calibration run
    sequence s_calWr; psel && penable && pwrite && paddr == pllc_pkg::MASTER_OFS && !pwdata[22]; endsequence
    sequence s_hold8; cal[*8]; endsequence
    property p_calgo; s_calWr |-> ##[1:2] cal; endproperty
    a_calgo: assert property (p_calgo) else $error("cal not started");
    property p_calhold; $rose(cal) |-> s_hold8; endproperty
    a_calhold: assert property (p_calhold) else $error("cal force short");
    property p_calend; $rose(cal) |-> ##[1:1000] !cal; endproperty
    a_calend: assert property (p_calend) else $error("cal never ends");
    property p_rd22; psel && penable && !pwrite && paddr == pllc_pkg::MASTER_OFS |-> prdata[22]; endproperty
    a_rd22: assert property (p_rd22) else $error("cal disable read 0");
    property p_pd1; primary_output_powerdown_pin[*6] |-> !primaryOutEnable; endproperty
    a_pd1: assert property (p_pd1) else $error("out1 not off");
    property p_pd2; secondary_output_powerdown_pin[*6] |-> !secondaryOutEnable; endproperty
    a_pd2: assert property (p_pd2) else $error("out2 not off");
    property p_boost; dampReduce |-> pump_current_code == pllc_pkg::PUMP_MAX; endproperty
    a_boost: assert property (p_boost) else $error("no boost in fast lock");
    property p_fastend; $rose(dampReduce) |-> ##[1:1000] !dampReduce; endproperty
    a_fastend: assert property (p_fastend) else $error("fast lock stuck");
endmodule
bind pllc_ctrl pllc_sva u_sva (.*);
`default_nettype wire

//--- sim/pllc_loop_model.sv
`default_nettype none
// Analog loop stand-in: reference keeps running, so it is stable before any calibration
module pllc_loop_model #(parameter logic [7:0] TARGET = 8'h5A) (
    input  wire logic       mclk,
    input  wire logic [3:0] skew,
    input  wire logic [7:0] oscSelectWord,
    output logic            compareClk, pfdUp, pfdDown, oscFast
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ph = 4'h0;  // Phase in a 16-cycle compare period
    always @(posedge mclk) ph <= ph + 4'h1;
    assign compareClk = ph[3];
    assign pfdUp = ph < 4'h2;
    assign pfdDown = (ph - skew) < 4'h2;  // Skew of zero keeps both pulses aligned
    assign oscFast = oscSelectWord > TARGET;  // Oscillator too high for the trial word
endmodule
`default_nettype wire

//--- sim/tb_pllc_ctrl.sv
`default_nettype none
module tb_pllc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] TGT = 8'h5A;  // Band the model oscillator settles on
    logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic primary_output_powerdown_pin = 1'b0, secondary_output_powerdown_pin = 1'b0;
    logic [7:0] paddr = 8'h00, oscSelectWord;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0] skew = 4'h0;
    logic pready, pslverr, compareClk, pfdUp, pfdDown, oscFast, lockOut, dampReduce;
    logic oscillator_tune_voltage_force, primaryOutEnable, secondaryOutEnable;
    logic [4:0] pump_current_code;
    logic [16:0] divideValue;
    int error_cnt = 0, samples_checked = 0;
    always #4 mclk = ~mclk;
    pllc_ctrl uut (.*);
    pllc_loop_model #(.TARGET(TGT)) lm (.*);
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge mclk) penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin error_cnt++; complete_run(); end
        @(posedge mclk);
    endtask
    // Bounded wait for a level on an output
    task automatic waitSig(ref logic s, input logic v);
        int n = 0;
        while (s !== v) begin
            @(posedge mclk);
            if (++n > 3000) begin error_cnt++; complete_run(); end
        end
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, pllc_pkg::OUT_CFG_OFS, 32'h0);
        chk(rd, 32'h0000_0003, "outcfg reset");
        apb(1'b0, pllc_pkg::MASTER_OFS, 32'h0);
        chk(rd[22], 1'b1, "cal disable read");
        apb(1'b0, 8'h1C, 32'h0);
        chk({rd[0], err}, 2'h1, "unmapped");
        apb(1'b1, pllc_pkg::OUT_CFG_OFS, 32'h0000_0002);
        apb(1'b1, pllc_pkg::FAST_CFG_OFS, 32'h0000_2014);
        apb(1'b1, pllc_pkg::MASTER_OFS, 32'h000A_0200);
        waitSig(oscillator_tune_voltage_force, 1'b1);
        @(posedge mclk);
        chk({dampReduce, pump_current_code}, 6'h3F, "fast boost");
        waitSig(oscillator_tune_voltage_force, 1'b0);
        chk(oscSelectWord, TGT, "osc select");
        chk(divideValue, 17'h0_0200, "divider");
        waitSig(dampReduce, 1'b0);
        chk(pump_current_code, 5'h05, "pump code");
        waitSig(lockOut, 1'b1);
        chk({primaryOutEnable, secondaryOutEnable}, 2'h2, "out enables");
        primary_output_powerdown_pin <= 1'b1; secondary_output_powerdown_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(primaryOutEnable, 1'b0, "pin powerdown");
        primary_output_powerdown_pin <= 1'b0; secondary_output_powerdown_pin <= 1'b0;
        apb(1'b1, pllc_pkg::OUT_CFG_OFS, 32'h0000_0006);
        apb(1'b1, pllc_pkg::LOCK_CFG_OFS, 32'h0000_00C0);
        repeat (3) @(posedge mclk);
        chk(lockOut, 1'b0, "inverted lock");
        skew <= 4'h4;
        waitSig(oscillator_tune_voltage_force, 1'b1);
        chk({lockOut, primaryOutEnable}, 2'h2, "unlock mute");
        skew <= 4'h0;
        waitSig(oscillator_tune_voltage_force, 1'b0);
        apb(1'b1, pllc_pkg::MASTER_OFS, 32'h004A_0200);
        chk(oscillator_tune_voltage_force, 1'b0, "cal off");
        complete_run();
    end
endmodule
`default_nettype wire
